// ==== mul_pkg.sv ====
// constants and register map for the registered 16x16 array multiplier
package mul_pkg;

  // operand and product widths
  localparam int unsigned OP_W   = 16;
  localparam int unsigned PROD_W = 32;

  // product fifo shape
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_AW    = 3;
  localparam int unsigned FIFO_CW    = 4;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] STATUS_OFF  = 8'h04;
  localparam logic [7:0] PRODUCT_OFF = 8'h08;
  localparam logic [7:0] OPERAND_OFF = 8'h0c;

  // control register fields
  localparam int unsigned CTRL_PUSH_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;

  // status register fields
  localparam int unsigned STAT_EMPTY_BIT = 0;
  localparam int unsigned STAT_FULL_BIT  = 1;
  localparam int unsigned STAT_OVF_BIT   = 2;
  localparam int unsigned STAT_CNT_LSB   = 4;

  // rounding constants, one into the bit just below the lsb of the upper half
  localparam logic [PROD_W-1:0] ROUND_FULL  = 32'h0000_8000;
  localparam logic [PROD_W-1:0] ROUND_SHIFT = 32'h0000_4000;

  // reset values of datapath registers
  localparam logic [OP_W-1:0]   OP_RESET   = 16'h0000;
  localparam logic [PROD_W-1:0] PROD_RESET = 32'h0000_0000;

endpackage

// ==== mul_top.sv ====
// registered 16x16 array multiplier with product fifo and apb register access
//
// Summary of operation
// - multiply two 16-bit operands, any sign mix
// - mode bit 0 unsigned, 1 two's complement
// - x operand captured on x clock rise
// - y operand captured from shared pins
// - lower half loaded on lower product clock
// - four independent register clocks, upper separate
// - format high full, low shifted 31-bit
// - passthrough makes both product registers transparent
// - half select low upper, high lower
// - product port has its own enable
// - lower half drives back on y pins
// - y pin driver gated by own enable
// - rounding adds one into lower portion
// - round request captured by x or y clock
//
// Added by the designer: the register addresses and the APB interface to the registers.

// fifo of products, parameterised width and depth, flop storage
module mul_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3,
  parameter int unsigned CW    = 4
) (
  // clock, reset, enable
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // fill level
  output logic [CW-1:0]         level
);

  logic [WIDTH-1:0] mem_q [DEPTH];   // storage words
  logic [AW-1:0]    wr_q;            // write index
  logic [AW-1:0]    rd_q;            // read index
  logic [CW-1:0]    cnt_q;           // words held

  wire push = in_valid & in_ready;   // accepted word
  wire pop  = out_valid & out_ready; // drained word

  // honest flags straight from the count
  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign level     = cnt_q;

  // pointers and count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end

  // storage words, one per generate slot
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_word
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        mem_q[i] <= '0;
      else if (clk_en && push && wr_q == AW'(i))
        mem_q[i] <= in_data;
    end
  end

endmodule

// the multiplier itself
module mul_top (
  // system clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // register clocks, sampled as synchronous levels
  input  wire logic        x_operand_clock,
  input  wire logic        y_operand_clock,
  input  wire logic        upper_product_clock,
  input  wire logic        lower_product_clock,
  // operand inputs and modes
  input  wire logic [15:0] x_data,
  input  wire logic        x_sign_mode,
  input  wire logic        y_sign_mode,
  input  wire logic        round_request,
  // product control
  input  wire logic        format_select,
  input  wire logic        passthrough_control,
  input  wire logic        output_half_select,
  input  wire logic        product_port_enable_n,
  input  wire logic        lower_half_y_enable_n,
  // product port, three-state as value and enable
  output logic [15:0]      product_out,
  output logic             product_oe,
  // shared y pins, three-state as in, out and enable
  input  wire logic [15:0] y_in,
  output logic [15:0]      y_out,
  output logic             y_oe,
  // fill side ready of the product fifo
  output logic             product_fifo_ready
);

  // previous levels of the four register clocks
  logic xclk_q;
  logic yclk_q;
  logic mclk_q;
  logic lclk_q;

  // input registers
  logic [15:0] x_q;                 // x operand
  logic        xmode_q;             // x sign mode
  logic [15:0] y_q;                 // y operand
  logic        ymode_q;             // y sign mode
  logic        round_q;             // round request

  // product registers
  logic [15:0] upper_q;             // upper product half
  logic [15:0] lower_q;             // lower product half

  // pin output flops
  logic [15:0] pout_q;
  logic        poe_q;
  logic [15:0] yout_q;
  logic        yoe_q;
  logic        fready_q;

  // apb state
  logic        ctrl_push_q;         // products enter fifo when set
  logic        ovf_q;               // sticky: product lost on full fifo
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  // rising edges of the register clocks; inputs are already synchronous
  wire x_rise = x_operand_clock & ~xclk_q;
  wire y_rise = y_operand_clock & ~yclk_q;
  wire m_rise = upper_product_clock & ~mclk_q;
  wire l_rise = lower_product_clock & ~lclk_q;

  // operand extension to 17 bits by mode, then a signed product
  wire signed [16:0] x_ext = {xmode_q & x_q[15], x_q};
  wire signed [16:0] y_ext = {ymode_q & y_q[15], y_q};
  wire signed [33:0] prod_full = x_ext * y_ext;
  wire [31:0]        prod_raw  = prod_full[31:0];

  // rounding into the bit just below the lsb of what becomes the upper half
  wire [31:0] round_add  = format_select ? mul_pkg::ROUND_FULL : mul_pkg::ROUND_SHIFT;
  wire [31:0] prod_round = prod_raw + (round_q ? round_add : 32'h0000_0000);

  // format adjust: shifted form keeps sign in lower msb
  wire [15:0] upper_d = format_select ? prod_round[31:16]
                                      : prod_round[30:15];
  wire [15:0] lower_d = format_select ? prod_round[15:0]
                                      : {prod_round[31], prod_round[14:0]};

  // load strobes; passthrough loads every cycle so the product follows
  wire upper_ld = m_rise | passthrough_control;
  wire lower_ld = l_rise | passthrough_control;

  // fifo wiring
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire [3:0]  fifo_level;

  // apb decode
  wire setup    = psel & ~penable;
  wire access   = psel & penable & pready_q;
  wire wr_done  = access & pwrite;
  wire rd_done  = access & ~pwrite;
  wire hit_ctrl = (paddr == mul_pkg::CTRL_OFF);
  wire hit_stat = (paddr == mul_pkg::STATUS_OFF);
  wire hit_prod = (paddr == mul_pkg::PRODUCT_OFF);
  wire hit_oper = (paddr == mul_pkg::OPERAND_OFF);
  wire mapped   = hit_ctrl | hit_stat | hit_prod | hit_oper;

  // each upper product clock rise offers the whole product to the fifo while push is enabled
  wire push_req  = m_rise & ctrl_push_q;
  wire push_lost = push_req & ~fifo_in_ready;
  wire pop_req   = rd_done & hit_prod & fifo_out_valid;
  wire ovf_clr   = wr_done & hit_stat & pwdata[mul_pkg::STAT_OVF_BIT];

  // status word
  wire [31:0] status_word = {24'h00_0000, fifo_level,
                             1'b0, ovf_q, ~fifo_in_ready, ~fifo_out_valid};

  // read data selection
  wire [31:0] rdata_sel = hit_ctrl ? {31'h0000_0000, ctrl_push_q} :
                          hit_stat ? status_word :
                          hit_prod ? (fifo_out_valid ? fifo_out_data : 32'h0000_0000) :
                          hit_oper ? {y_q, x_q} : 32'h0000_0000;

  // product fifo between the multiplier and software
  mul_fifo #(
    .WIDTH (mul_pkg::PROD_W),
    .DEPTH (mul_pkg::FIFO_DEPTH),
    .AW    (mul_pkg::FIFO_AW),
    .CW    (mul_pkg::FIFO_CW)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .in_valid  (push_req),
    .in_ready  (fifo_in_ready),
    .in_data   ({upper_d, lower_d}),
    .out_valid (fifo_out_valid),
    .out_ready (pop_req),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // clock edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xclk_q <= 1'b0;
      yclk_q <= 1'b0;
      mclk_q <= 1'b0;
      lclk_q <= 1'b0;
    end
    else if (clk_en)
    begin
      xclk_q <= x_operand_clock;
      yclk_q <= y_operand_clock;
      mclk_q <= upper_product_clock;
      lclk_q <= lower_product_clock;
    end
  end

  // x input register with its mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      x_q     <= mul_pkg::OP_RESET;
      xmode_q <= 1'b0;
    end
    else if (clk_en && x_rise)
    begin
      x_q     <= x_data;
      xmode_q <= x_sign_mode;
    end
  end

  // y input register from the shared pins, with its mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      y_q     <= mul_pkg::OP_RESET;
      ymode_q <= 1'b0;
    end
    else if (clk_en && y_rise)
    begin
      y_q     <= y_in;
      ymode_q <= y_sign_mode;
    end
  end

  // round request strobed by either operand clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      round_q <= 1'b0;
    else if (clk_en && (x_rise || y_rise))
      round_q <= round_request;
  end

  // upper product register on its own clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      upper_q <= mul_pkg::OP_RESET;
    else if (clk_en && upper_ld)
      upper_q <= upper_d;
  end

  // lower product register on its own clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lower_q <= mul_pkg::OP_RESET;
    else if (clk_en && lower_ld)
      lower_q <= lower_d;
  end

  // pin drivers; one cycle behind the product registers, outputs stay flopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pout_q   <= mul_pkg::OP_RESET;
      poe_q    <= 1'b0;
      yout_q   <= mul_pkg::OP_RESET;
      yoe_q    <= 1'b0;
      fready_q <= 1'b0;
    end
    else if (clk_en)
    begin
      pout_q   <= output_half_select ? lower_q : upper_q;
      poe_q    <= ~product_port_enable_n;
      yout_q   <= lower_q;
      yoe_q    <= ~lower_half_y_enable_n;
      fready_q <= fifo_in_ready;
    end
  end

  // control register and sticky overflow; a new loss beats the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_push_q <= mul_pkg::CTRL_RESET[mul_pkg::CTRL_PUSH_EN_BIT];
      ovf_q       <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_done && hit_ctrl)
        ctrl_push_q <= pwdata[mul_pkg::CTRL_PUSH_EN_BIT];
      if (push_lost)
        ovf_q <= 1'b1;
      else if (ovf_clr)
        ovf_q <= 1'b0;
    end
  end

  // apb answer: data latched in setup, pready in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (clk_en)
    begin
      pready_q <= setup;
      if (setup)
      begin
        prdata_q  <= pwrite ? 32'h0000_0000 : rdata_sel;
        pslverr_q <= ~mapped;
      end
      else if (access)
      begin
        prdata_q  <= 32'h0000_0000;
        pslverr_q <= 1'b0;
      end
    end
  end

  // ports
  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign product_out        = pout_q;
  assign product_oe         = poe_q;
  assign y_out              = yout_q;
  assign y_oe               = yoe_q;
  assign product_fifo_ready = fready_q;

endmodule

// ==== mul_host.sv ====
// host model: strobes operand and product clocks and owns the shared y pins
module mul_host (
  // request from the bench
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic [15:0] xv,
  input  wire logic [15:0] yv,
  // device pins
  input  wire logic [15:0] y_out,
  input  wire logic        y_oe,
  output logic             x_operand_clock,
  output logic             y_operand_clock,
  output logic             upper_product_clock,
  output logic             lower_product_clock,
  output logic [15:0]      x_data,
  output logic [15:0]      y_in,
  output logic             busy
);
  logic [2:0]  st_q;   // step of one multiply
  logic [15:0] last_q; // moving pattern for released lines
  // operand clocks rise together, product clocks two cycles later
  assign x_operand_clock     = (st_q == 3'h1);
  assign y_operand_clock     = (st_q == 3'h1);
  assign upper_product_clock = (st_q == 3'h3);
  assign lower_product_clock = (st_q == 3'h3);
  assign busy                = go | (st_q != 3'h0);
  // data only while strobed, so a late sample shows garbage
  assign x_data = x_operand_clock ? xv : ~last_q;
  // host lets go of y whenever the device drives it
  assign y_in = y_oe ? y_out : (y_operand_clock ? yv : ~last_q);
  // step counter, one multiply every six cycles; idle while reset is held
  always_ff @(posedge pclk)
  begin
    if (!presetn)
    begin
      st_q   <= 3'h0;
      last_q <= 16'h0000;
    end
    else
    begin
      st_q   <= (st_q == 3'h0) ? {2'h0, go} : ((st_q == 3'h5) ? 3'h0 : st_q + 3'h1);
      last_q <= ~last_q;
    end
  end
endmodule

// ==== mul_sva.sv ====
// port checker for the multiplier
module mul_sva (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // product path
  input wire logic        upper_product_clock,
  input wire logic        passthrough_control,
  input wire logic        output_half_select,
  input wire logic        product_port_enable_n,
  input wire logic        lower_half_y_enable_n,
  input wire logic [15:0] product_out,
  input wire logic        product_oe,
  input wire logic [15:0] y_out,
  input wire logic        y_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_prod_oe;
    $past(presetn, 2) |-> product_oe == !$past(product_port_enable_n);
  endproperty
  a_prod_oe: assert property (p_prod_oe) else $error("product enable wrong");
  property p_y_oe;
    $past(presetn, 2) |-> y_oe == !$past(lower_half_y_enable_n);
  endproperty
  a_y_oe: assert property (p_y_oe) else $error("y enable wrong");
  property p_hold;
    (!output_half_select && !passthrough_control && !upper_product_clock)[*3]
      |-> $stable(product_out);
  endproperty
  a_hold: assert property (p_hold) else $error("upper half moved");
  property p_y_same;
    y_oe && product_oe && $past(output_half_select) |-> y_out == product_out;
  endproperty
  a_y_same: assert property (p_y_same) else $error("y differs");
  property p_setup;
    psel && !penable |=> pready;
  endproperty
  a_setup: assert property (p_setup) else $error("no ready");
  property p_one;
    pready |=> !pready;
  endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_idle;
    !psel |=> !pready;
  endproperty
  a_idle: assert property (p_idle) else $error("stray ready");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("bad error reply");
  c_err: cover property (pslverr);
  c_y: cover property (y_oe && product_oe);
  c_pt: cover property (passthrough_control && $changed(product_out));
endmodule

// ==== tb_top.sv ====
// testbench: random products, fifo fill and drain, apb access
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, go, busy, f, err;
  logic x_operand_clock, y_operand_clock, upper_product_clock, lower_product_clock;
  logic x_sign_mode, y_sign_mode, round_request, format_select, passthrough_control;
  logic output_half_select, product_port_enable_n, lower_half_y_enable_n;
  logic product_oe, y_oe, product_fifo_ready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, e, q;
  logic [31:0] ex [8]; // products expected out of the fifo
  logic [15:0] x_data, y_in, y_out, product_out, xv, yv, lfsr, a, b;
  logic [1:0]  m;
  int          failures, samples_checked, i, n;
  mul_top  DUT (.*);
  mul_host u_host (.*);
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // 16-bit lfsr step
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // reference product, round added before the split
  function automatic logic [31:0] exp_prod(input logic [15:0] x, y, input logic sx, sy, r, ff);
    logic signed [33:0] p;
    p = $signed({sx & x[15], x}) * $signed({sy & y[15], y});
    p = p + (r ? (ff ? 34'h8000 : 34'h4000) : 34'h0);
    return ff ? p[31:0] : {p[30:15], p[31], p[14:0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] ev, sv);
    samples_checked++;
    if (sv !== ev)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, ev, sv);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      failures++;
      tally_and_finish();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // waits for the host model to finish, a stuck host ends the run
  task automatic wait_idle;
    for (n = 0; n < 20 && busy === 1'b1; n++) @(posedge pclk);
    if (busy === 1'b1)
    begin
      failures++;
      tally_and_finish();
    end
  endtask
  // one multiply through the host model, then both halves and the y pins
  task automatic run_op(input logic [31:0] ev);
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    wait_idle();
    chk("upper", {16'h0, ev[31:16]}, {16'h0, product_out});
    chk("oe", {31'h0, !product_port_enable_n}, {31'h0, product_oe});
    output_half_select <= 1'b1;
    lower_half_y_enable_n <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("lower", {16'h0, ev[15:0]}, {16'h0, product_out});
    chk("y pins", {15'h0, 1'b1, ev[15:0]}, {15'h0, y_oe, y_out});
    output_half_select <= 1'b0;
    lower_half_y_enable_n <= 1'b1;
    @(posedge pclk);
  endtask
  initial
  begin
    {clk_en, presetn, psel, penable, pwrite, go, x_sign_mode, y_sign_mode} = 8'h80;
    {round_request, passthrough_control, output_half_select} = 3'h0;
    {format_select, product_port_enable_n, lower_half_y_enable_n} = 3'h7;
    {paddr, pwdata, xv, yv, failures, samples_checked} = '0;
    lfsr = 16'h005c;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h1, q);
    // ten products into an eight deep fifo, every sign mix
    for (i = 0; i < 10; i++)
    begin
      lfsr = nxt(lfsr);
      a = lfsr;
      lfsr = nxt(lfsr);
      b = lfsr;
      m = (i < 4) ? i[1:0] : lfsr[1:0];
      if (i == 0) {a, b, m} = {32'hffff_ffff, 2'b00};
      if (i == 1) {a, b, m} = {32'h8000_8000, 2'b11};
      f = !(&m) | lfsr[5];
      e = exp_prod(a, b, m[1], m[0], lfsr[7], f);
      if (i < 8) ex[i] = e;
      @(posedge pclk);
      {xv, yv, x_sign_mode, y_sign_mode} <= {a, b, m};
      {round_request, format_select, product_port_enable_n} <= {lfsr[7], f, lfsr[9]};
      run_op(e);
    end
    chk("ready", 32'h0, {31'h0, product_fifo_ready});
    apb(1'b0, 8'h04, 32'h0);
    chk("status full", 32'h86, q);
    apb(1'b0, 8'h0c, 32'h0);
    chk("operands", {b, a}, q);
    for (i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'h08, 32'h0);
      chk("fifo", ex[i], q);
    end
    apb(1'b0, 8'h04, 32'h0);
    chk("status empty", 32'h05, q);
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b0, 8'h04, 32'h0);
    chk("cleared", 32'h01, q);
    apb(1'b0, 8'h08, 32'h0);
    chk("empty pop", 32'h0, q);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    // transparent registers show the product one cycle early
    @(posedge pclk);
    {passthrough_control, output_half_select, format_select} <= 3'h7;
    {xv, yv, x_sign_mode, y_sign_mode, round_request} <= {32'h0003_0005, 3'h0};
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (n = 0; n < 20 && upper_product_clock !== 1'b1; n++) @(posedge pclk);
    if (upper_product_clock !== 1'b1)
    begin
      failures++;
      tally_and_finish();
    end
    @(posedge pclk);
    chk("passthrough", 32'h000f, {16'h0, product_out});
    // enable low: a multiply strobed meanwhile must leave the operands alone
    wait_idle();
    @(posedge pclk);
    {clk_en, passthrough_control} <= 2'b00;
    {xv, yv} <= 32'h1234_4321;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    wait_idle();
    clk_en <= 1'b1;
    apb(1'b0, 8'h0c, 32'h0);
    chk("frozen operands", 32'h0005_0003, q);
    repeat (8) @(posedge pclk);
    tally_and_finish();
  end
endmodule
bind mul_top mul_sva u_sva (.*);
